/* File: hw/bhr_pkg.sv */
// Purpose: shared constants and types for the bus hang recovery block
// Assumes: core clock of 250 MHz, standard-mode bus timing by default
// Notes:   pulse widths and stall timeout are derived from times in ns
package bhr_pkg;

  // =====================================================================
  // timing
  localparam int unsigned CLK_PERIOD_NS     = 4;
  localparam int unsigned SCK_LOW_MIN_NS    = 4700;
  localparam int unsigned SCK_HIGH_MIN_NS   = 4000;
  localparam int unsigned SLOW_SCK_HIGH_NS  = 5000;
  localparam int unsigned STALL_FACTOR      = 4;
  localparam int unsigned STALL_NS          = SLOW_SCK_HIGH_NS * STALL_FACTOR;
  // least times round up to whole cycles
  localparam int unsigned SCK_LOW_CYC  = (SCK_LOW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SCK_HIGH_CYC = (SCK_HIGH_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned STALL_CYC    = (STALL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RECOVERY_PULSES = 9;
  localparam int unsigned CNT_W  = 16;
  localparam int unsigned PULSE_W = 4;

  // =====================================================================
  // types
  typedef enum {
    BHR_IDLE,
    BHR_WATCH,
    BHR_LOW,
    BHR_HIGH,
    BHR_STOP_LOW,
    BHR_STOP_SETUP,
    BHR_CHECK
  } bhr_state_e;

  typedef struct packed {
    logic sda;
    logic sck;
  } bhr_line_s;

endpackage

/* File: hw/bhr_core.sv */
// Purpose: frees an I2C bus held low by a slave after a master reset
// Assumes: open-drain lines with external pull-ups; reset inputs are
//          asynchronous and active high (1 = master in reset)
// Notes:   one clock; line inputs pass two flip-flops before use
//
// Contract
// - on master reset, sample SDA to see whether it is stuck low
// - single master: SDA low in reset gives nine SCK pulses ending high
// - recovery pulses keep minimum high and low durations
// - after pulses, sample SDA again to confirm release
// - lines only pulled low or released, never driven high
// - take each master reset as input; observe and drive SDA and SCK
// - several masters: start detection when any master is in reset
// - reset seen with SDA high: bus not hung, do nothing
// - SDA low with SCK toggling is legal traffic, do nothing
// - SDA low and SCK high beyond stall timeout means hang, recover
// - stall timeout is four times slowest longest SCK high time
// - sample SDA and SCK many times per bus clock period
// - multi-master: generate stop condition after the nine pulses
// - start is SDA falling while SCK high; bus busy until stop
// - stop is SDA rising while SCK high; releases the bus
`timescale 1ns/10ps
`default_nettype none

module bhr_core
  import bhr_pkg::*;
#(
  parameter int unsigned           NUM_MASTERS  = 2,
  parameter bit                    MULTI_MASTER = 1'b1,
  parameter logic [CNT_W-1:0]      LOW_CYC      = CNT_W'(SCK_LOW_CYC),
  parameter logic [CNT_W-1:0]      HIGH_CYC     = CNT_W'(SCK_HIGH_CYC),
  parameter logic [CNT_W-1:0]      STALL_LIMIT  = CNT_W'(STALL_CYC)
) (
  input  wire logic                   CORE_CLK,
  input  wire logic                   RST_N,
  input  wire logic [NUM_MASTERS-1:0] PROCESSOR_RESET_STATUS,
  input  wire logic                   SDA_I,
  output logic                        SDA_O,
  output logic                        SDA_OE,
  input  wire logic                   SCK_I,
  output logic                        SCK_O,
  output logic                        SCK_OE,
  output logic                        RECOVERY_BUSY,
  output logic                        HANG_DETECTED
);

  // =====================================================================
  // input synchronisers
  bhr_line_s                  line_meta_reg;
  bhr_line_s                  line_reg;
  logic [NUM_MASTERS-1:0]     rst_meta_reg;
  logic [NUM_MASTERS-1:0]     rst_sync_reg;
  logic                       sck_prev_reg;

  // sampling every core cycle gives thousands of samples per bus period
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      line_meta_reg <= '{sda: 1'b1, sck: 1'b1};
      line_reg      <= '{sda: 1'b1, sck: 1'b1};
      rst_meta_reg  <= '0;
      rst_sync_reg  <= '0;
      sck_prev_reg  <= 1'b1;
    end else begin
      line_meta_reg <= '{sda: SDA_I, sck: SCK_I};
      line_reg      <= line_meta_reg;
      rst_meta_reg  <= PROCESSOR_RESET_STATUS;
      rst_sync_reg  <= rst_meta_reg;
      sck_prev_reg  <= line_reg.sck;
    end
  end

  logic any_reset;
  logic sck_edge;
  assign any_reset = |rst_sync_reg;
  assign sck_edge  = line_reg.sck ^ sck_prev_reg;

  // =====================================================================
  // recovery state machine
  bhr_state_e             state_reg,  state_next;
  logic [CNT_W-1:0]       cnt_reg,    cnt_next;
  logic [PULSE_W-1:0]     pulse_reg,  pulse_next;
  logic                   sck_low_reg, sck_low_next;
  logic                   sda_low_reg, sda_low_next;
  logic                   hang_reg,   hang_next;

  always_comb begin
    state_next   = state_reg;
    cnt_next     = cnt_reg;
    pulse_next   = pulse_reg;
    sck_low_next = 1'b0;
    sda_low_next = 1'b0;
    hang_next    = hang_reg;
    case (state_reg)
      BHR_IDLE: begin
        cnt_next = '0;
        if (any_reset) begin
          state_next = BHR_WATCH;
        end
      end
      BHR_WATCH: begin
        if (!any_reset) begin
          state_next = BHR_IDLE;
          cnt_next   = '0;
        end else if (line_reg.sda) begin
          cnt_next = '0;
        end else if (!MULTI_MASTER) begin
          state_next = BHR_LOW;
          cnt_next   = '0;
          pulse_next = '0;
          hang_next  = 1'b1;
        end else if (sck_edge || !line_reg.sck) begin
          cnt_next = '0;
        end else if (cnt_reg >= STALL_LIMIT) begin
          state_next = BHR_LOW;
          cnt_next   = '0;
          pulse_next = '0;
          hang_next  = 1'b1;
        end else begin
          cnt_next = cnt_reg + CNT_W'(1);
        end
      end
      BHR_LOW: begin
        sck_low_next = 1'b1;
        if (cnt_reg >= LOW_CYC - CNT_W'(1)) begin
          state_next = BHR_HIGH;
          cnt_next   = '0;
        end else begin
          cnt_next = cnt_reg + CNT_W'(1);
        end
      end
      BHR_HIGH: begin
        // a slave stretching SCK holds the high count off
        if (!line_reg.sck) begin
          cnt_next = '0;
        end else if (cnt_reg >= HIGH_CYC - CNT_W'(1)) begin
          cnt_next   = '0;
          pulse_next = pulse_reg + PULSE_W'(1);
          if (pulse_reg == PULSE_W'(RECOVERY_PULSES - 1)) begin
            state_next = MULTI_MASTER ? BHR_STOP_LOW : BHR_CHECK;
          end else begin
            state_next = BHR_LOW;
          end
        end else begin
          cnt_next = cnt_reg + CNT_W'(1);
        end
      end
      BHR_STOP_LOW: begin
        // SCK goes low one cycle before SDA, so the SDA fall is never a start
        sck_low_next = 1'b1;
        sda_low_next = sck_low_reg;
        if (cnt_reg >= LOW_CYC - CNT_W'(1)) begin
          state_next = BHR_STOP_SETUP;
          cnt_next   = '0;
        end else begin
          cnt_next = cnt_reg + CNT_W'(1);
        end
      end
      BHR_STOP_SETUP: begin
        sda_low_next = 1'b1;
        // a stretched SCK delays the stop until the line is really high
        if (!line_reg.sck) begin
          cnt_next = '0;
        end else if (cnt_reg >= HIGH_CYC - CNT_W'(1)) begin
          state_next = BHR_CHECK;
          cnt_next   = '0;
        end else begin
          cnt_next = cnt_reg + CNT_W'(1);
        end
      end
      BHR_CHECK: begin
        // let the released line settle through the synchroniser
        if (cnt_reg >= HIGH_CYC - CNT_W'(1)) begin
          cnt_next = '0;
          if (line_reg.sda) begin
            state_next = BHR_IDLE;
            hang_next  = 1'b0;
          end else begin
            state_next = BHR_LOW;
            pulse_next = '0;
          end
        end else begin
          cnt_next = cnt_reg + CNT_W'(1);
        end
      end
      default: begin
        state_next = BHR_IDLE;
        cnt_next   = '0;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      state_reg   <= BHR_IDLE;
      cnt_reg     <= '0;
      pulse_reg   <= '0;
      sck_low_reg <= 1'b0;
      sda_low_reg <= 1'b0;
      hang_reg    <= 1'b0;
    end else begin
      state_reg   <= state_next;
      cnt_reg     <= cnt_next;
      pulse_reg   <= pulse_next;
      sck_low_reg <= sck_low_next;
      sda_low_reg <= sda_low_next;
      hang_reg    <= hang_next;
    end
  end

  // =====================================================================
  // open-drain outputs: data always low, only the enable moves
  assign SDA_O  = 1'b0;
  assign SCK_O  = 1'b0;
  assign SDA_OE = sda_low_reg;
  assign SCK_OE = sck_low_reg;
  assign RECOVERY_BUSY = (state_reg != BHR_IDLE) && (state_reg != BHR_WATCH);
  assign HANG_DETECTED = hang_reg;

endmodule // bhr_core

`default_nettype wire

/* File: testbench/bhr_slave_model.sv */
// Purpose: slave memory caught mid read, holding SDA low
// Assumes: scl is the resolved wire level
// Notes:   all data bits are zero, so SDA stays low until done
`timescale 1ns/10ps
`default_nettype none
module bhr_slave_model (
  input  wire logic       arm,
  input  wire logic [3:0] bits,
  input  wire logic       scl,
  output logic            sda_low
);
  int n;
  initial begin
    n = 0;
    sda_low = 1'b0;
  end
  always @(posedge arm) begin
    n = bits;
    // an acknowledge slot is simply one more low bit
    sda_low = 1'b1;
  end
  // next bit only after scl falls, so SDA holds while scl high
  always @(negedge scl) begin
    if (n > 0) n = n - 1;
    if (n == 0) sda_low = 1'b0;
  end
endmodule // bhr_slave_model
`default_nettype wire

/* File: testbench/bhr_core_chk.sv */
// Purpose: port assertions for bhr_core
// Assumes: one clock, RST_N synchronous active low
// Notes:   high width floor of 4 matches the bench HIGH_CYC
`timescale 1ns/10ps
`default_nettype none
module bhr_core_chk
  import bhr_pkg::*;
#(
  parameter int unsigned      NUM_MASTERS = 2,
  parameter logic [CNT_W-1:0] LOW_CYC     = 4,
  parameter logic [CNT_W-1:0] STALL_LIMIT = 80
) (
  input wire logic                   CORE_CLK,
  input wire logic                   RST_N,
  input wire logic [NUM_MASTERS-1:0] PROCESSOR_RESET_STATUS,
  input wire logic                   SDA_I,
  input wire logic                   SDA_O,
  input wire logic                   SDA_OE,
  input wire logic                   SCK_I,
  input wire logic                   SCK_O,
  input wire logic                   SCK_OE,
  input wire logic                   RECOVERY_BUSY,
  input wire logic                   HANG_DETECTED
);
  localparam int LC = int'(LOW_CYC);
  // ====
  // raw stall length and pulse count since the last stop
  logic [CNT_W-1:0] stall_reg, stall_next;
  logic [3:0]       rise_reg, rise_next;
  logic             sck_q_reg, sda_q_reg;
  always_comb begin
    stall_next = (!SDA_I && SCK_I && |PROCESSOR_RESET_STATUS) ? stall_reg + 1'b1 : '0;
    rise_next = rise_reg + {3'h0, SCK_OE && !sck_q_reg};
    if (!RECOVERY_BUSY || (SDA_OE && !sda_q_reg)) rise_next = 4'h0;
  end
  always_ff @(posedge CORE_CLK) begin
    stall_reg <= RST_N ? stall_next : '0;
    rise_reg  <= RST_N ? rise_next : 4'h0;
    sck_q_reg <= SCK_OE;
    sda_q_reg <= SDA_OE;
  end
  // ====
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  AST_OPEN_DRAIN: assert property (!SDA_O && !SCK_O)
    else $error("line output not low");
  AST_LOW_WIDTH: assert property ($rose(SCK_OE) |-> ##[LC:LC] $fell(SCK_OE))
    else $error("scl low phase width wrong");
  AST_HIGH_WIDTH: assert property ($fell(SCK_OE) |-> !SCK_OE [*4])
    else $error("scl high phase too short");
  AST_STALL: assert property ($rose(HANG_DETECTED) |-> stall_reg >= STALL_LIMIT)
    else $error("hang declared before stall timeout");
  AST_HANG_ACT: assert property ($rose(HANG_DETECTED) |-> RECOVERY_BUSY ##1 SCK_OE)
    else $error("hang without recovery start");
  AST_NINE: assert property ($rose(SDA_OE) |-> SCK_OE && $past(SCK_OE) && rise_reg == 4'hA)
    else $error("stop not after nine pulses");
  AST_STOP: assert property ($fell(SDA_OE) |-> SCK_I && !SCK_OE)
    else $error("sda released while scl low");
  AST_SDA_BUSY: assert property (SDA_OE |-> RECOVERY_BUSY)
    else $error("sda pulled outside recovery");
endmodule // bhr_core_chk
bind bhr_core bhr_core_chk #(
  .NUM_MASTERS(NUM_MASTERS), .LOW_CYC(LOW_CYC), .STALL_LIMIT(STALL_LIMIT)) u_chk (.*);
`default_nettype wire

/* File: testbench/bhr_core_tb.sv */
// Purpose: scenario bench for bhr_core
// Assumes: short pulse and stall counts set at the instance
// Notes:   other master clocks at 160 ns, its 80 ns high phase 4x below the stall limit
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin num_errors++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, ex, got); end end
module bhr_core_tb
  import bhr_pkg::*;
;
  logic       clk, rst_n, arm, oth_sda, oth_sck, sda_o, sda_oe, sck_o, sck_oe;
  logic       busy, hang, slv_low;
  logic [1:0] prs;
  logic [3:0] bits;
  bhr_line_s  bus;
  int         num_errors, tests_run, cyc;
  // wired AND with pull-ups
  assign bus = {!(sda_oe || slv_low || oth_sda), !(sck_oe || oth_sck)};
  bhr_core #(.NUM_MASTERS(2), .MULTI_MASTER(1'b1), .LOW_CYC(16'h0004),
    .HIGH_CYC(16'h0004), .STALL_LIMIT(16'h0050)) DUT (
    .CORE_CLK(clk), .RST_N(rst_n), .PROCESSOR_RESET_STATUS(prs), .SDA_I(bus.sda),
    .SDA_O(sda_o), .SDA_OE(sda_oe), .SCK_I(bus.sck), .SCK_O(sck_o), .SCK_OE(sck_oe),
    .RECOVERY_BUSY(busy), .HANG_DETECTED(hang));
  bhr_slave_model u_slv (.arm(arm), .bits(bits), .scl(bus.sck), .sda_low(slv_low));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      num_errors++;
      summarize();
    end
  end
  task automatic summarize();
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // ====
  // waits for the hang, then counts scl falls on the wire
  task automatic recover(input int exp);
    int   k, f;
    logic last;
    f = 0;
    last = 1'b1;
    step(1);
    `CHK("bus held low", 1'b0, bus.sda)
    for (k = 1; k < 400 && hang !== 1'b1; k++) step(1);
    `CHK("stall time", 1'b1, (k >= 80) && (hang === 1'b1))
    for (k = 0; k < 1500 && busy === 1'b1; k++) begin
      step(1);
      f += int'(last && !bus.sck);
      last = bus.sck;
      if (f == 10 && exp == 20) `CHK("hang kept", 1'b1, hang)
    end
    step(2);
    `CHK("scl falls", exp, f)
    `CHK("sda freed", 1'b1, bus.sda)
    `CHK("hang clear", 1'b0, hang)
    arm = 1'b0;
    prs = 2'b00;
    step(4);
  endtask
  task automatic t_quiet();
    prs = 2'b01;
    step(150);
    `CHK("no hang sda high", 1'b0, hang)
    `CHK("no pull", 1'b0, sck_oe | sda_oe)
    prs = 2'b00;
    step(4);
  endtask
  task automatic t_traffic();
    prs = 2'b10;
    oth_sda = 1'b1;
    for (int k = 0; k < 20; k++) begin
      oth_sck = k[0];
      step(20);
    end
    `CHK("no hang on traffic", 1'b0, hang)
    oth_sda = 1'b0;
    oth_sck = 1'b0;
    prs = 2'b00;
    step(4);
  endtask
  // second master in reset, slave has five bits left
  task automatic t_hang();
    prs = 2'b10;
    bits = 4'h5;
    arm = 1'b1;
    recover(10);
  endtask
  // twelve bits outlast one round, so recovery runs twice
  task automatic t_retry();
    prs = 2'b01;
    bits = 4'hC;
    arm = 1'b1;
    recover(20);
  endtask
  initial begin
    rst_n = 1'b0;
    prs = 2'b00;
    arm = 1'b0;
    bits = 4'h0;
    oth_sda = 1'b0;
    oth_sck = 1'b0;
    step(6);
    rst_n = 1'b1;
    step(3);
    t_quiet();
    t_traffic();
    t_hang();
    t_retry();
    summarize();
  end
endmodule // bhr_core_tb
`default_nettype wire
